// >>> include/pdd_map.vh
// object indices, subindices, delivery values and limits of the drive parameter dictionary
// assumes: included by the dictionary core only; values are 8/16/32-bit sized constants
`ifndef PDD_MAP_VH
`define PDD_MAP_VH

// object indices
`define PDD_IDX_SM_TYPES 16'h1C00
`define PDD_IDX_SM0_ASSIGN 16'h1C10
`define PDD_IDX_SM1_ASSIGN 16'h1C11
`define PDD_IDX_SM2_ASSIGN 16'h1C12
`define PDD_IDX_SM3_ASSIGN 16'h1C13
`define PDD_IDX_SCRATCH 16'h2000
`define PDD_IDX_GOAL 16'h2001
`define PDD_IDX_PRESENT 16'h2003
`define PDD_IDX_OFFSET 16'h2004
`define PDD_IDX_FERR 16'h2005
`define PDD_IDX_WINDOW 16'h2006
`define PDD_IDX_NUM 16'h2010
`define PDD_IDX_DEN 16'h2011
`define PDD_IDX_POS_RPM 16'h2012
`define PDD_IDX_MAN_RPM 16'h2013
`define PDD_IDX_TORQUE 16'h2014
`define PDD_IDX_UPPER 16'h2016
`define PDD_IDX_START_TORQUE 16'h2018
`define PDD_IDX_START_MS 16'h2019

// subindex layout
`define PDD_SUB_COUNT 8'h00
`define PDD_SUB_FIRST 8'h01
`define PDD_SM_COUNT 8'h04
`define PDD_SM0_ASSIGN_COUNT 8'h00
`define PDD_SM1_ASSIGN_COUNT 8'h00
`define PDD_SM2_ASSIGN_COUNT 8'h01
`define PDD_SM3_ASSIGN_COUNT 8'h01
`define PDD_RXPDO_MAP 16'h1600
`define PDD_TXPDO_MAP 16'h1A00
`define PDD_SCRATCH_COUNT 8'h0A

// delivery values
`define PDD_SCRATCH_RST 16'h0000
`define PDD_GOAL_RST 32'h00000000
`define PDD_OFFSET_RST 32'h00000000
`define PDD_FERR_RST 16'h0000
`define PDD_WINDOW_RST 16'h0002
`define PDD_SCALE_RST 16'h0190
`define PDD_UPPER_RST 32'h00018B50
`define PDD_START_MS_RST 16'h00C8

// value ranges
`define PDD_FERR_MAX 16'h03E8
`define PDD_WINDOW_MIN 16'h0001
`define PDD_WINDOW_BASE_MAX 16'h0064
`define PDD_SCALE_MIN 16'h0001
`define PDD_SCALE_MAX 16'h2710
`define PDD_REV_LO_MULT 16'h00FD
`define PDD_REV_HI_MULT 16'h0003

`endif

// >>> core/pdd_core.v
// parameter dictionary of a positioning drive: object access, scaling, limits and position status
// assumes: object requests, axis inputs and positions come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pdd_map.vh"

// How it works
// - sync-manager type object lists four entries, types 1 to 4, read-only
// - assignment lists of sync managers zero and one report zero entries
// - sync manager two assigns one receive mapping, 0x1600, as 16-bit entry
// - sync manager three assigns one transmit mapping, 0x1A00, as 16-bit entry
// - ten writable scratch words after read-only count of ten, zero at delivery
// - signed goal position held in user units, writable, zero after reset
// - writing present position re-references it without motion, only at standstill
// - correction offset shifts goal, present and limit; standstill-only, default zero
// - following-error flag when command-to-actual deviation exceeds 16-bit limit
// - in-position flag when goal-to-actual difference lies within window, default two
// - window maximum scales with resolution; window writes only at standstill
// - numerator and denominator set resolution, default 400, standstill-only writes
// - positioning runs use their own maximum speed
// - manual runs use a separate maximum speed
// - start-up torque limit during start phase, running limit afterwards
// - start phase lasts a programmable number of milliseconds, default 200
// - upper travel bound caps goals; not below mapping end minus 253 revolutions
// - upper bound not above mapping end minus three revolutions; standstill-only
module pdd_core #(
  parameter CLK_KHZ = 25000,
  parameter [15:0] POS_RPM_RST = 16'h0064,
  parameter [15:0] MAN_RPM_RST = 16'h0032,
  parameter [15:0] TORQUE_RST = 16'h0064,
  parameter [15:0] START_TORQUE_RST = 16'h0064
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // object access from the mailbox service
  input wire obj_req,
  input wire obj_wr,
  input wire [15:0] obj_index,
  input wire [7:0] obj_sub,
  input wire [31:0] obj_wdata,
  output wire obj_ack,
  output wire obj_abort,
  output wire [31:0] obj_rdata,
  // axis state
  input wire axis_standstill,
  input wire manual_run,
  input wire move_start,
  input wire [31:0] raw_position,
  input wire [31:0] cmd_position,
  input wire [31:0] map_end,
  // motion limits and status
  output wire [31:0] target_raw,
  output wire [31:0] upper_raw,
  output wire [15:0] speed_limit,
  output wire [15:0] torque_limit,
  output wire start_phase,
  output wire in_position,
  output wire following_error
);

  localparam [31:0] MS_CYCLES = CLK_KHZ;
  localparam integer SCRATCH_WORDS = `PDD_SCRATCH_COUNT;

  reg ack_q;
  reg abort_q;
  reg [31:0] rdata_q;
  reg [15:0] scratch_q [0:SCRATCH_WORDS-1];
  reg [31:0] goal_q;
  reg [31:0] ref_adj_q;
  reg [31:0] offset_q;
  reg [15:0] ferr_q;
  reg [15:0] window_q;
  reg [15:0] num_q;
  reg [15:0] den_q;
  reg [15:0] pos_rpm_q;
  reg [15:0] man_rpm_q;
  reg [15:0] torque_q;
  reg [31:0] upper_q;
  reg [15:0] start_torque_q;
  reg [15:0] start_ms_q;
  reg [31:0] div_q;
  reg [15:0] ms_left_q;
  reg [31:0] target_raw_q;
  reg [31:0] upper_raw_q;
  reg [15:0] speed_q;
  reg [15:0] torque_lim_q;
  reg start_phase_q;
  reg in_pos_q;
  reg ferr_flag_q;
  reg [15:0] scratch_rd;

  reg rd_ok;
  reg [31:0] rd_val;
  reg wr_ok;
  reg [31:0] target_raw_d;
  reg [31:0] upper_raw_d;
  wire [31:0] present_user;
  wire [31:0] upper_lo;
  wire [31:0] upper_hi;
  wire [31:0] win_scaled;
  wire [31:0] win_cap;
  wire single;
  wire scratch_sub;
  wire do_write;
  wire req_ok;
  wire ms_tick;
  wire start_busy;
  wire [SCRATCH_WORDS-1:0] scratch_hit;
  integer i;
  integer j;
  genvar g;

  function [31:0] absdiff;
    input [31:0] a;
    input [31:0] b;
    reg [31:0] d;
    begin
      d = a - b;
      absdiff = d[31] ? (32'h00000000 - d) : d;
    end
  endfunction

  // signed a <= b on 32-bit words
  function not_above;
    input [31:0] a;
    input [31:0] b;
    begin
      not_above = ($signed(a) <= $signed(b));
    end
  endfunction

  // 16-bit objects refuse anything in the upper half of the word
  function fits16;
    input [31:0] v;
    begin
      fits16 = (v[31:16] == 16'h0000);
    end
  endfunction

  function [31:0] zx16;
    input [15:0] v;
    begin
      zx16 = {16'h0000, v};
    end
  endfunction

  function [31:0] zx8;
    input [7:0] v;
    begin
      zx8 = {24'h000000, v};
    end
  endfunction

  assign single = (obj_sub == `PDD_SUB_COUNT);
  assign scratch_sub = |scratch_hit;
  assign present_user = raw_position + ref_adj_q + offset_q;
  // numerator counts user units per revolution
  assign upper_lo = map_end - {16'h0000, num_q} * {16'h0000, `PDD_REV_LO_MULT};
  assign upper_hi = map_end - {16'h0000, num_q} * {16'h0000, `PDD_REV_HI_MULT};
  // cross-multiplied to avoid a divider: window*den <= base*num
  assign win_scaled = {16'h0000, obj_wdata[15:0]} * {16'h0000, den_q};
  assign win_cap = {16'h0000, `PDD_WINDOW_BASE_MAX} * {16'h0000, num_q};
  assign do_write = obj_req && obj_wr && wr_ok;
  assign req_ok = obj_wr ? wr_ok : rd_ok;
  assign ms_tick = (div_q == MS_CYCLES - 32'h00000001);
  assign start_busy = move_start || (ms_left_q != 16'h0000);

  // one subindex match per scratch word, shared by the read select and the write enables
  generate
    for (g = 0; g < SCRATCH_WORDS; g = g + 1) begin : g_scratch_hit
      localparam integer WORD_SUB = `PDD_SUB_FIRST + g;
      assign scratch_hit[g] = ({24'h000000, obj_sub} == WORD_SUB);
    end
  endgenerate

  // select by match, not by index, so a bad subindex never reads past the array
  always @* begin
    scratch_rd = `PDD_SCRATCH_RST;
    for (j = 0; j < SCRATCH_WORDS; j = j + 1) begin
      if (scratch_hit[j]) begin
        scratch_rd = scratch_q[j];
      end
    end
  end

  always @* begin
    rd_ok = single;
    rd_val = 32'h00000000;
    case (obj_index)
      `PDD_IDX_SM_TYPES: begin
        rd_ok = (obj_sub <= `PDD_SM_COUNT);
        rd_val = single ? zx8(`PDD_SM_COUNT) : zx8(obj_sub);
      end
      `PDD_IDX_SM0_ASSIGN: rd_val = zx8(`PDD_SM0_ASSIGN_COUNT);
      `PDD_IDX_SM1_ASSIGN: rd_val = zx8(`PDD_SM1_ASSIGN_COUNT);
      `PDD_IDX_SM2_ASSIGN: begin
        rd_ok = single || (obj_sub == `PDD_SUB_FIRST);
        rd_val = single ? zx8(`PDD_SM2_ASSIGN_COUNT) : zx16(`PDD_RXPDO_MAP);
      end
      `PDD_IDX_SM3_ASSIGN: begin
        rd_ok = single || (obj_sub == `PDD_SUB_FIRST);
        rd_val = single ? zx8(`PDD_SM3_ASSIGN_COUNT) : zx16(`PDD_TXPDO_MAP);
      end
      `PDD_IDX_SCRATCH: begin
        rd_ok = single || scratch_sub;
        rd_val = single ? zx8(`PDD_SCRATCH_COUNT) : zx16(scratch_rd);
      end
      `PDD_IDX_GOAL: rd_val = goal_q;
      `PDD_IDX_PRESENT: rd_val = present_user;
      `PDD_IDX_OFFSET: rd_val = offset_q;
      `PDD_IDX_FERR: rd_val = zx16(ferr_q);
      `PDD_IDX_WINDOW: rd_val = zx16(window_q);
      `PDD_IDX_NUM: rd_val = zx16(num_q);
      `PDD_IDX_DEN: rd_val = zx16(den_q);
      `PDD_IDX_POS_RPM: rd_val = zx16(pos_rpm_q);
      `PDD_IDX_MAN_RPM: rd_val = zx16(man_rpm_q);
      `PDD_IDX_TORQUE: rd_val = zx16(torque_q);
      `PDD_IDX_UPPER: rd_val = upper_q;
      `PDD_IDX_START_TORQUE: rd_val = zx16(start_torque_q);
      `PDD_IDX_START_MS: rd_val = zx16(start_ms_q);
      default: rd_ok = 1'b0;
    endcase
  end

  // write acceptance; anything not listed, including the read-only objects, is refused
  always @* begin
    wr_ok = 1'b0;
    case (obj_index)
      `PDD_IDX_SCRATCH: wr_ok = scratch_sub && fits16(obj_wdata);
      `PDD_IDX_GOAL: wr_ok = single && not_above(obj_wdata, upper_q);
      `PDD_IDX_PRESENT: wr_ok = single && axis_standstill;
      `PDD_IDX_OFFSET: wr_ok = single && axis_standstill;
      `PDD_IDX_FERR: wr_ok = single && fits16(obj_wdata) && (obj_wdata[15:0] <= `PDD_FERR_MAX);
      `PDD_IDX_WINDOW:
        wr_ok = single && axis_standstill && fits16(obj_wdata) &&
                (obj_wdata[15:0] >= `PDD_WINDOW_MIN) && (win_scaled <= win_cap);
      `PDD_IDX_NUM, `PDD_IDX_DEN:
        wr_ok = single && axis_standstill && fits16(obj_wdata) &&
                (obj_wdata[15:0] >= `PDD_SCALE_MIN) && (obj_wdata[15:0] <= `PDD_SCALE_MAX);
      `PDD_IDX_POS_RPM, `PDD_IDX_MAN_RPM, `PDD_IDX_TORQUE, `PDD_IDX_START_TORQUE, `PDD_IDX_START_MS:
        wr_ok = single && fits16(obj_wdata);
      `PDD_IDX_UPPER:
        wr_ok = single && axis_standstill && not_above(upper_lo, obj_wdata) &&
                not_above(obj_wdata, upper_hi);
      default: wr_ok = 1'b0;
    endcase
  end

  // object answers: one cycle after the request
  always @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= obj_req && req_ok;
      abort_q <= obj_req && !req_ok;
      if (obj_req) begin
        rdata_q <= (!obj_wr && rd_ok) ? rd_val : 32'h00000000;
      end
    end
  end

  // scratch words; backup to nonvolatile memory is outside this block
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < SCRATCH_WORDS; i = i + 1) begin
        scratch_q[i] <= `PDD_SCRATCH_RST;
      end
    end else begin
      for (i = 0; i < SCRATCH_WORDS; i = i + 1) begin
        if (do_write && (obj_index == `PDD_IDX_SCRATCH) && scratch_hit[i]) begin
          scratch_q[i] <= obj_wdata[15:0];
        end
      end
    end
  end

  // parameter storage; backup to nonvolatile memory is outside this block
  always @(posedge clock) begin
    if (rst) begin
      goal_q <= `PDD_GOAL_RST;
      ref_adj_q <= 32'h00000000;
      offset_q <= `PDD_OFFSET_RST;
      ferr_q <= `PDD_FERR_RST;
      window_q <= `PDD_WINDOW_RST;
      num_q <= `PDD_SCALE_RST;
      den_q <= `PDD_SCALE_RST;
      pos_rpm_q <= POS_RPM_RST;
      man_rpm_q <= MAN_RPM_RST;
      torque_q <= TORQUE_RST;
      upper_q <= `PDD_UPPER_RST;
      start_torque_q <= START_TORQUE_RST;
      start_ms_q <= `PDD_START_MS_RST;
    end else if (do_write) begin
      case (obj_index)
        `PDD_IDX_GOAL: goal_q <= obj_wdata;
        // only the reference moves, the axis stays where it is
        `PDD_IDX_PRESENT: ref_adj_q <= obj_wdata - raw_position - offset_q;
        `PDD_IDX_OFFSET: offset_q <= obj_wdata;
        `PDD_IDX_FERR: ferr_q <= obj_wdata[15:0];
        `PDD_IDX_WINDOW: window_q <= obj_wdata[15:0];
        `PDD_IDX_NUM: num_q <= obj_wdata[15:0];
        `PDD_IDX_DEN: den_q <= obj_wdata[15:0];
        `PDD_IDX_POS_RPM: pos_rpm_q <= obj_wdata[15:0];
        `PDD_IDX_MAN_RPM: man_rpm_q <= obj_wdata[15:0];
        `PDD_IDX_TORQUE: torque_q <= obj_wdata[15:0];
        `PDD_IDX_UPPER: upper_q <= obj_wdata;
        `PDD_IDX_START_TORQUE: start_torque_q <= obj_wdata[15:0];
        `PDD_IDX_START_MS: start_ms_q <= obj_wdata[15:0];
        default: goal_q <= goal_q;
      endcase
    end
  end

  // start phase timer in milliseconds; a new move restarts it
  always @(posedge clock) begin
    if (rst) begin
      div_q <= 32'h00000000;
      ms_left_q <= 16'h0000;
    end else if (move_start) begin
      div_q <= 32'h00000000;
      ms_left_q <= start_ms_q;
    end else if (ms_left_q != 16'h0000) begin
      if (ms_tick) begin
        div_q <= 32'h00000000;
        ms_left_q <= ms_left_q - 16'h0001;
      end else begin
        div_q <= div_q + 32'h00000001;
      end
    end
  end

  // user space to motor space: strip offset and reference
  always @* begin
    target_raw_d = goal_q - offset_q - ref_adj_q;
    upper_raw_d = upper_q - offset_q - ref_adj_q;
  end

  always @(posedge clock) begin
    if (rst) begin
      target_raw_q <= 32'h00000000;
      upper_raw_q <= 32'h00000000;
      speed_q <= 16'h0000;
      torque_lim_q <= 16'h0000;
      start_phase_q <= 1'b0;
      in_pos_q <= 1'b0;
      ferr_flag_q <= 1'b0;
    end else begin
      target_raw_q <= target_raw_d;
      upper_raw_q <= upper_raw_d;
      speed_q <= manual_run ? man_rpm_q : pos_rpm_q;
      start_phase_q <= start_busy;
      torque_lim_q <= start_busy ? start_torque_q : torque_q;
      in_pos_q <= (absdiff(target_raw_d, raw_position) <= {16'h0000, window_q});
      ferr_flag_q <= (absdiff(cmd_position, raw_position) > {16'h0000, ferr_q});
    end
  end

  assign obj_ack = ack_q;
  assign obj_abort = abort_q;
  assign obj_rdata = rdata_q;
  assign target_raw = target_raw_q;
  assign upper_raw = upper_raw_q;
  assign speed_limit = speed_q;
  assign torque_limit = torque_lim_q;
  assign start_phase = start_phase_q;
  assign in_position = in_pos_q;
  assign following_error = ferr_flag_q;

endmodule // pdd_core
`default_nettype wire

// >>> verif/pdd_core_sva.sv
// checker for the parameter dictionary core, bound onto pdd_core
// assumes: one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pdd_core_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // object access
  input wire logic obj_req,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic obj_ack,
  input wire logic obj_abort,
  input wire logic [31:0] obj_rdata,
  // axis and status
  input wire logic axis_standstill,
  input wire logic move_start,
  input wire logic [31:0] raw_position,
  input wire logic [31:0] cmd_position,
  input wire logic start_phase,
  input wire logic following_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic moving_wr = obj_req && obj_wr && !axis_standstill;
  a_types_read: assert property (obj_req && !obj_wr && obj_index == 16'h1C00 && obj_sub inside {[1:4]}
    |=> obj_ack && obj_rdata == {24'h000000, $past(obj_sub)}) else $error("sm type read wrong");
  a_ro_refuse: assert property (obj_req && obj_wr && obj_index >= 16'h1C00 && obj_index <= 16'h1C13
    |=> obj_abort && !obj_ack) else $error("read-only write accepted");
  a_offset_hold: assert property (moving_wr && obj_index == 16'h2004 |=> obj_abort)
    else $error("offset written while moving");
  a_window_hold: assert property (moving_wr && obj_index == 16'h2006 |=> obj_abort)
    else $error("window written while moving");
  a_scale_hold: assert property (moving_wr && obj_index inside {16'h2010, 16'h2011} |=> obj_abort)
    else $error("scaling written while moving");
  a_upper_hold: assert property (moving_wr && obj_index == 16'h2016 |=> obj_abort)
    else $error("upper bound written while moving");
  a_answer_once: assert property (obj_req |=> obj_ack != obj_abort) else $error("no single answer");
  a_ferr_clear: assert property (cmd_position == raw_position |=> !following_error)
    else $error("following error without deviation");
  a_start_rise: assert property (move_start |=> start_phase) else $error("start phase missing");
endmodule // pdd_core_sva
bind pdd_core pdd_core_sva u_sva (.clock(clock), .rst(rst), .obj_req(obj_req), .obj_wr(obj_wr),
  .obj_index(obj_index), .obj_sub(obj_sub), .obj_ack(obj_ack), .obj_abort(obj_abort), .obj_rdata(obj_rdata),
  .axis_standstill(axis_standstill), .move_start(move_start), .raw_position(raw_position),
  .cmd_position(cmd_position), .start_phase(start_phase), .following_error(following_error));
`default_nettype wire

// >>> verif/pdd_master.sv
// object-access master model standing in for the fieldbus controller
// assumes: the answer stands in the cycle after the taking edge
`timescale 1ns/1ps
`default_nettype none
module pdd_master (
  // clock
  input wire logic clock,
  // request
  output var logic obj_req,
  output var logic obj_wr,
  output var logic [15:0] obj_index,
  output var logic [7:0] obj_sub,
  output var logic [31:0] obj_wdata,
  // answer
  input wire logic obj_ack,
  input wire logic obj_abort,
  input wire logic [31:0] obj_rdata
);
  initial begin
    obj_req = 1'b0;
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_sub = 8'h00;
    obj_wdata = 32'h00000000;
  end
  task access(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] v,
    output logic [1:0] r, output logic [31:0] d);
    @(negedge clock);
    obj_req = 1'b1;
    obj_wr = w;
    obj_index = i;
    obj_sub = s;
    obj_wdata = v;
    @(negedge clock);
    obj_req = 1'b0;
    // released index and data lines must not keep showing the last value
    obj_wdata = ~v;
    obj_index = ~i;
    r = {obj_ack, obj_abort};
    d = obj_rdata;
  endtask
endmodule // pdd_master
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench of the parameter dictionary core
// assumes: pdd_master issues object requests; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic stand = 1'b1;
  logic manual = 1'b0;
  logic mstart = 1'b0;
  logic [31:0] raw = 32'h00000000;
  logic [31:0] cmd = 32'h00000000;
  logic [31:0] mend = 32'h00030D40;
  wire req, wr, ack, ab, sph, inp, fe;
  wire [15:0] idx, spd, trq;
  wire [7:0] sub;
  wire [31:0] wd, rd, traw, uraw;
  integer fail_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  initial forever #20 clock = ~clock;
  pdd_master u_m (.clock(clock), .obj_req(req), .obj_wr(wr), .obj_index(idx), .obj_sub(sub),
    .obj_wdata(wd), .obj_ack(ack), .obj_abort(ab), .obj_rdata(rd));
  // short millisecond so start periods stay a few tens of cycles
  pdd_core #(.CLK_KHZ(10)) dut (.clock(clock), .rst(rst), .obj_req(req), .obj_wr(wr), .obj_index(idx),
    .obj_sub(sub), .obj_wdata(wd), .obj_ack(ack), .obj_abort(ab), .obj_rdata(rd), .axis_standstill(stand),
    .manual_run(manual), .move_start(mstart), .raw_position(raw), .cmd_position(cmd), .map_end(mend),
    .target_raw(traw), .upper_raw(uraw), .speed_limit(spd), .torque_limit(trq), .start_phase(sph),
    .in_position(inp), .following_error(fe));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr_chk(input string nm, input logic [15:0] i, input logic [31:0] v, input logic [1:0] e);
    logic [1:0] r;
    logic [31:0] d;
    u_m.access(1'b1, i, 8'h00, v, r, d);
    chk(nm, {30'h0, e}, {30'h0, r});
  endtask
  task rd_chk(input string nm, input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    logic [1:0] r;
    logic [31:0] d;
    u_m.access(1'b0, i, s, 32'h00000000, r, d);
    chk({nm, " resp"}, 32'h2, {30'h0, r});
    chk(nm, e, d);
  endtask
  task wait2;
    repeat (2) @(negedge clock);
  endtask
  task t_defaults;
    for (int s = 0; s < 5; s++) rd_chk("sm type", 16'h1C00, s[7:0], (s == 0) ? 32'h4 : s);
    rd_chk("sm0 count", 16'h1C10, 8'h00, 32'h0);
    rd_chk("sm1 count", 16'h1C11, 8'h00, 32'h0);
    rd_chk("sm2 count", 16'h1C12, 8'h00, 32'h1);
    rd_chk("sm2 map", 16'h1C12, 8'h01, 32'h1600);
    rd_chk("sm3 count", 16'h1C13, 8'h00, 32'h1);
    rd_chk("sm3 map", 16'h1C13, 8'h01, 32'h1A00);
    rd_chk("scratch count", 16'h2000, 8'h00, 32'hA);
    for (int s = 1; s < 11; s++) rd_chk("scratch init", 16'h2000, s[7:0], 32'h0);
    rd_chk("goal", 16'h2001, 8'h00, 32'h0);
    rd_chk("offset", 16'h2004, 8'h00, 32'h0);
    rd_chk("ferr limit", 16'h2005, 8'h00, 32'h0);
    rd_chk("window", 16'h2006, 8'h00, 32'h2);
    rd_chk("numerator", 16'h2010, 8'h00, 32'h190);
    rd_chk("denominator", 16'h2011, 8'h00, 32'h190);
    rd_chk("upper", 16'h2016, 8'h00, 32'h18B50);
    $display("t_defaults done");
  endtask
  task t_status;
    logic [1:0] r;
    logic [31:0] d;
    chk("in pos at 0", 32'h1, {31'h0, inp});
    raw = 32'h2;
    wait2;
    chk("in pos at 2", 32'h1, {31'h0, inp});
    raw = 32'h3;
    wait2;
    chk("out of pos at 3", 32'h0, {31'h0, inp});
    raw = 32'h0;
    cmd = 32'h1;
    wait2;
    chk("ferr over 0", 32'h1, {31'h0, fe});
    cmd = 32'h0;
    for (int s = 1; s < 11; s++) begin
      u_m.access(1'b1, 16'h2000, s[7:0], s * 32'h1111, r, d);
      chk("scratch wr", 32'h2, {30'h0, r});
    end
    for (int s = 1; s < 11; s++) rd_chk("scratch rd", 16'h2000, s[7:0], s * 32'h1111);
    wr_chk("scratch count wr", 16'h2000, 32'h5, 2'b01);
    wr_chk("sm type wr", 16'h1C00, 32'h4, 2'b01);
    $display("t_status done");
  endtask
  task t_moving;
    logic [15:0] ix [6] = '{16'h2003, 16'h2004, 16'h2006, 16'h2010, 16'h2011, 16'h2016};
    logic [31:0] ex [6] = '{32'h0, 32'h0, 32'h2, 32'h190, 32'h190, 32'h18B50};
    stand = 1'b0;
    for (int k = 0; k < 6; k++) wr_chk("moving wr", ix[k], 32'h5, 2'b01);
    stand = 1'b1;
    for (int k = 0; k < 6; k++) rd_chk("moving kept", ix[k], 8'h00, ex[k]);
    $display("t_moving done");
  endtask
  task t_ranges;
    wr_chk("window 0", 16'h2006, 32'h0, 2'b01);
    wr_chk("window 101", 16'h2006, 32'h65, 2'b01);
    wr_chk("window 100", 16'h2006, 32'h64, 2'b10);
    wr_chk("den 200", 16'h2011, 32'hC8, 2'b10);
    wr_chk("window 201", 16'h2006, 32'hC9, 2'b01);
    wr_chk("window 200", 16'h2006, 32'hC8, 2'b10);
    wr_chk("num 0", 16'h2010, 32'h0, 2'b01);
    wr_chk("num 10001", 16'h2010, 32'h2711, 2'b01);
    wr_chk("den 400", 16'h2011, 32'h190, 2'b10);
    wr_chk("window 2", 16'h2006, 32'h2, 2'b10);
    wr_chk("ferr 1001", 16'h2005, 32'h3E9, 2'b01);
    wr_chk("ferr 1000", 16'h2005, 32'h3E8, 2'b10);
    cmd = 32'h3E8;
    wait2;
    chk("ferr at limit", 32'h0, {31'h0, fe});
    cmd = 32'h3E9;
    wait2;
    chk("ferr over limit", 32'h1, {31'h0, fe});
    cmd = 32'h0;
    wr_chk("upper low-1", 16'h2016, 32'h181EF, 2'b01);
    wr_chk("upper low", 16'h2016, 32'h181F0, 2'b10);
    wr_chk("upper high+1", 16'h2016, 32'h30891, 2'b01);
    wr_chk("upper high", 16'h2016, 32'h30890, 2'b10);
    wr_chk("goal over", 16'h2001, 32'h30891, 2'b01);
    wr_chk("goal at bound", 16'h2001, 32'h30890, 2'b10);
    wait2;
    chk("target raw", 32'h30890, traw);
    wr_chk("goal 0", 16'h2001, 32'h0, 2'b10);
    $display("t_ranges done");
  endtask
  task t_motion;
    wr_chk("start torque", 16'h2018, 32'h10, 2'b10);
    wr_chk("start ms", 16'h2019, 32'h3, 2'b10);
    manual = 1'b1;
    wait2;
    chk("manual speed", 32'h32, {16'h0, spd});
    manual = 1'b0;
    wait2;
    chk("posi speed", 32'h64, {16'h0, spd});
    mstart = 1'b1;
    @(negedge clock);
    mstart = 1'b0;
    repeat (17) @(negedge clock);
    chk("in start", 32'h1, {31'h0, sph});
    chk("start torque", 32'h10, {16'h0, trq});
    repeat (20) @(negedge clock);
    chk("start over", 32'h0, {31'h0, sph});
    chk("run torque", 32'h64, {16'h0, trq});
    $display("t_motion done");
  endtask
  task t_reference;
    raw = 32'h3E8;
    wr_chk("present wr", 16'h2003, 32'h1388, 2'b10);
    rd_chk("present", 16'h2003, 8'h00, 32'h1388);
    raw = 32'h3F2;
    wr_chk("offset wr", 16'h2004, 32'h10, 2'b10);
    rd_chk("present shifted", 16'h2003, 8'h00, 32'h13A2);
    chk("target shifted", 32'hFFFFF050, traw);
    chk("upper shifted", 32'h0002F8E0, uraw);
    $display("t_reference done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_defaults;
    t_status;
    t_moving;
    // parameter changes only at standstill, before any run
    stand = 1'b1;
    t_ranges;
    t_motion;
    t_reference;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
